//--- src/prioritised_irq_controller.sv
// Prioritised interrupt controller with AXI4-Lite register access
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Pin zero goes to 04H at priority 1; group zero to 08H at priority 2.
// - Group one, timer one matches, goes to 0CH at priority 3.
// - Group two, timer two matches or EEPROM write, goes to 10H, priority 4.
// - Converter to 14H at priority 5; group three to 18H at priority 6.
// - Group four, time base one, SCF, detector, pump, to 1CH, priority 7.
// - Bit 0 of first primary register is global enable; zero blocks all.
// - First primary bits 6..1: group 1,0 and pin flags, then their enables.
// - Second primary: group 4,3, converter, group 2 flags, then enables.
// - Group A: EEPROM flag bit 6, timer zero flags 5,4, enables 2..0.
// - Group register B: timer one flags bits 5,4, enables bits 1,0.
// - Group register C: timer two flags bits 5,4, enables bits 1,0.
// - Group D: pin one, serial 1/0, time base 0; flags over enables.
// - Group E: detector, time base 1 flags 7,6; enables 3..0; no pump flag.
// - SCF flag is bit 4 of group E and resets to one; all else zero.
// - Bit 5 of group E never changes on a write.
// - Unimplemented bits read zero and ignore writes.
// - Disabled request still sets its flag but never branches.
// - Taking an interrupt clears the global enable.
// - Serving a group clears only the group flag, not member flags.
// - No request is acknowledged while the return stack is full.
module prioritised_irq_controller
(
  // Clock and reset
  input  wire logic                               aclk,
  input  wire logic                               aresetn,
  // AXI4-Lite write
  input  wire logic [irq_ctrl_pkg::ADDR_W-1:0]   awaddr,
  input  wire logic [2:0]                         awprot,
  input  wire logic                               awvalid,
  output logic                                    awready,
  input  wire logic [31:0]                        wdata,
  input  wire logic [3:0]                         wstrb,
  input  wire logic                               wvalid,
  output logic                                    wready,
  output logic [1:0]                              bresp,
  output logic                                    bvalid,
  input  wire logic                               bready,
  // AXI4-Lite read
  input  wire logic [irq_ctrl_pkg::ADDR_W-1:0]   araddr,
  input  wire logic [2:0]                         arprot,
  input  wire logic                               arvalid,
  output logic                                    arready,
  output logic [31:0]                             rdata,
  output logic [1:0]                              rresp,
  output logic                                    rvalid,
  input  wire logic                               rready,
  // Source events, one-cycle pulses
  input  wire logic                               pin_zero_event,
  input  wire logic                               pin_one_event,
  input  wire logic                               tmr_zero_amatch,
  input  wire logic                               tmr_zero_pmatch,
  input  wire logic                               tmr_one_amatch,
  input  wire logic                               tmr_one_pmatch,
  input  wire logic                               tmr_two_amatch,
  input  wire logic                               tmr_two_pmatch,
  input  wire logic                               eeprom_write_done,
  input  wire logic                               converter_done,
  input  wire logic                               timebase_zero_tick,
  input  wire logic                               timebase_one_tick,
  input  wire logic                               serial_zero_done,
  input  wire logic                               serial_one_done,
  input  wire logic                               voltage_detect_event,
  input  wire logic                               scf_event,
  input  wire logic                               charge_pump_event,
  // Core sequencer
  input  wire logic                               stack_full,
  input  wire logic                               irq_ack,
  output logic                                    irq_request,
  output logic [7:0]                              irq_vector
);
  import irq_ctrl_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [7:0] reg_mask(input logic [2:0] i);
    case (i)
      IDX_PRI_A:            reg_mask = MASK_PRI_A;
      IDX_PRI_B:            reg_mask = MASK_PRI_B;
      IDX_GRP_A:            reg_mask = MASK_GRP_A;
      IDX_GRP_B, IDX_GRP_C: reg_mask = MASK_GRP_BC;
      IDX_GRP_D:            reg_mask = MASK_GRP_D;
      IDX_GRP_E:            reg_mask = MASK_GRP_E;
      default:              reg_mask = RST_ZERO;
    endcase
  endfunction

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    addr_ok = (a[1:0] == 2'h0) && (a[ADDR_W-1:5] == '0) &&
              (a[4:2] <= IDX_GRP_E);
  endfunction

  // Lowest index is the highest priority
  function automatic logic [2:0] highest(input logic [NUM_VEC-1:0] p);
    highest = 3'h0;
    for (int k = NUM_VEC - 1; k >= 0; k--)
    begin
      if (p[k])
        highest = 3'(k);
    end
  endfunction

  function automatic logic [7:0] vector_of(input logic [2:0] i);
    vector_of = 8'(VEC_BASE + VEC_STEP * {5'h0, i});
  endfunction

  // ==========================================================
  // State
  logic [7:0]         regs      [NUM_REGS];
  logic [7:0]         next_regs [NUM_REGS];
  logic [7:0]         hw_set    [NUM_REGS];
  logic [7:0]         hw_clr    [NUM_REGS];
  logic               aw_held;
  logic               w_held;
  logic [2:0]         wr_idx;
  logic               wr_ok;
  logic [7:0]         w_byte;
  logic               w_lane;
  logic [2:0]         rd_idx;
  logic [2:0]         served_idx;
  logic [14:0]        term;
  logic [14:0]        term_q;
  logic [14:0]        rise;
  logic [NUM_VEC-1:0] pend;
  logic               aw_hs;
  logic               w_hs;
  logic               ar_hs;
  logic               wr_fire;
  logic               ack_take;
  logic               next_aw_held;
  logic               next_w_held;
  logic               next_bvalid;
  logic               next_rvalid;

  // ==========================================================
  // AXI4-Lite slave
  assign aw_hs        = awvalid && awready;
  assign w_hs         = wvalid && wready;
  assign ar_hs        = arvalid && arready;
  assign wr_fire      = aw_held && w_held && !bvalid;
  assign next_aw_held = (aw_held || aw_hs) && !wr_fire;
  assign next_w_held  = (w_held || w_hs) && !wr_fire;
  assign next_bvalid  = wr_fire || (bvalid && !bready);
  assign next_rvalid  = ar_hs || (rvalid && !rready);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      wr_idx  <= 3'h0;
      wr_ok   <= 1'b0;
      w_byte  <= 8'h00;
      w_lane  <= 1'b0;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      awready <= !next_aw_held && !next_bvalid;
      wready  <= !next_w_held && !next_bvalid;
      bvalid  <= next_bvalid;
      if (aw_hs)
      begin
        wr_idx <= awaddr[4:2];
        wr_ok  <= addr_ok(awaddr);
      end
      if (w_hs)
      begin
        w_byte <= wdata[7:0];
        w_lane <= wstrb[0];
      end
      if (wr_fire)
        bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Read data is a snapshot taken when the address is accepted
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
      rd_idx  <= 3'h0;
    end
    else
    begin
      arready <= !next_rvalid;
      rvalid  <= next_rvalid;
      if (ar_hs)
      begin
        rd_idx <= araddr[4:2];
        if (addr_ok(araddr))
        begin
          rdata <= {24'h0,
                    regs[araddr[4:2]] & reg_mask(araddr[4:2])};
          rresp <= RESP_OKAY;
        end
        else
        begin
          rdata <= 32'h0000_0000;
          rresp <= RESP_SLVERR;
        end
      end
    end
  end

  // ==========================================================
  // Grouped sources: a rise of flag-and-enable raises the group
  always_comb
  begin
    term[0]  = regs[IDX_GRP_A][BIT_TP_F] && regs[IDX_GRP_A][BIT_TP_E];
    term[1]  = regs[IDX_GRP_A][BIT_TA_F] && regs[IDX_GRP_A][BIT_TA_E];
    term[2]  = regs[IDX_GRP_B][BIT_TP_F] && regs[IDX_GRP_B][BIT_TP_E];
    term[3]  = regs[IDX_GRP_B][BIT_TA_F] && regs[IDX_GRP_B][BIT_TA_E];
    term[4]  = regs[IDX_GRP_C][BIT_TP_F] && regs[IDX_GRP_C][BIT_TP_E];
    term[5]  = regs[IDX_GRP_C][BIT_TA_F] && regs[IDX_GRP_C][BIT_TA_E];
    term[6]  = regs[IDX_GRP_A][BIT_EE_F] && regs[IDX_GRP_A][BIT_EE_E];
    for (int k = 0; k < 4; k++)
      term[7+k] = regs[IDX_GRP_D][BIT_TB0_F+k] && regs[IDX_GRP_D][k];
    term[11] = regs[IDX_GRP_E][BIT_LVD_F] && regs[IDX_GRP_E][BIT_LVD_E];
    term[12] = regs[IDX_GRP_E][BIT_TB1_F] && regs[IDX_GRP_E][BIT_TB1_E];
    term[13] = regs[IDX_GRP_E][BIT_SCF_F] && regs[IDX_GRP_E][BIT_SCF_E];
    // Pump has no flag of its own, its pulse feeds the group directly
    term[14] = charge_pump_event && regs[IDX_GRP_E][BIT_CHP_E];
  end

  // Edge rather than level, so an auto-cleared group does not re-fire
  // while the member flag still waits for software
  assign rise = term & ~term_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      term_q <= 15'h0000;
    else
      term_q <= term;
  end

  // ==========================================================
  // Hardware sets and clears
  assign ack_take = irq_ack && irq_request;

  always_comb
  begin
    for (int i = 0; i < NUM_REGS; i++)
    begin
      hw_set[i] = 8'h00;
      hw_clr[i] = 8'h00;
    end
    hw_set[IDX_PRI_A][BIT_PIN0_F] = pin_zero_event;
    hw_set[IDX_PRI_A][BIT_G0_F]   = |rise[1:0];
    hw_set[IDX_PRI_A][BIT_G1_F]   = |rise[3:2];
    hw_set[IDX_PRI_B][BIT_G2_F]   = |rise[6:4];
    hw_set[IDX_PRI_B][BIT_ADC_F]  = converter_done;
    hw_set[IDX_PRI_B][BIT_G3_F]   = |rise[10:7];
    hw_set[IDX_PRI_B][BIT_G4_F]   = |rise[14:11];
    hw_set[IDX_GRP_A][BIT_EE_F]   = eeprom_write_done;
    hw_set[IDX_GRP_A][BIT_TA_F]   = tmr_zero_amatch;
    hw_set[IDX_GRP_A][BIT_TP_F]   = tmr_zero_pmatch;
    hw_set[IDX_GRP_B][BIT_TA_F]   = tmr_one_amatch;
    hw_set[IDX_GRP_B][BIT_TP_F]   = tmr_one_pmatch;
    hw_set[IDX_GRP_C][BIT_TA_F]   = tmr_two_amatch;
    hw_set[IDX_GRP_C][BIT_TP_F]   = tmr_two_pmatch;
    hw_set[IDX_GRP_D][BIT_PIN1_F] = pin_one_event;
    hw_set[IDX_GRP_D][BIT_SPI1_F] = serial_one_done;
    hw_set[IDX_GRP_D][BIT_SPI0_F] = serial_zero_done;
    hw_set[IDX_GRP_D][BIT_TB0_F]  = timebase_zero_tick;
    hw_set[IDX_GRP_E][BIT_LVD_F]  = voltage_detect_event;
    hw_set[IDX_GRP_E][BIT_TB1_F]  = timebase_one_tick;
    hw_set[IDX_GRP_E][BIT_SCF_F]  = scf_event;
    if (ack_take)
    begin
      hw_clr[IDX_PRI_A][BIT_GIE] = 1'b1;
      // Only the primary or group flag; members stay for software
      if (served_idx < 3'h3)
        hw_clr[IDX_PRI_A][3'(BIT_PIN0_F) + served_idx] = 1'b1;
      else
        hw_clr[IDX_PRI_B][served_idx + 3'h1] = 1'b1;
    end
  end

  // Software write, then hardware clear, then hardware set: a set
  // arriving with a clear is never lost
  always_comb
  begin
    for (int i = 0; i < NUM_REGS; i++)
    begin
      next_regs[i] = regs[i];
      if (wr_fire && wr_ok && w_lane && (wr_idx == 3'(i)))
        next_regs[i] = w_byte & reg_mask(3'(i));
      next_regs[i] = (next_regs[i] & ~hw_clr[i]) | hw_set[i];
    end
  end

  always_ff @(posedge aclk)
  begin
    for (int i = 0; i < NUM_REGS; i++)
    begin
      if (!aresetn)
        regs[i] <= (3'(i) == IDX_GRP_E) ? RST_GRP_E : RST_ZERO;
      else
        regs[i] <= next_regs[i];
    end
  end

  // ==========================================================
  // Arbitration towards the core
  always_comb
  begin
    pend[0] = regs[IDX_PRI_A][BIT_PIN0_F] && regs[IDX_PRI_A][BIT_PIN0_E];
    pend[1] = regs[IDX_PRI_A][BIT_G0_F] && regs[IDX_PRI_A][BIT_G0_E];
    pend[2] = regs[IDX_PRI_A][BIT_G1_F] && regs[IDX_PRI_A][BIT_G1_E];
    pend[3] = regs[IDX_PRI_B][BIT_G2_F] && regs[IDX_PRI_B][BIT_G2_E];
    pend[4] = regs[IDX_PRI_B][BIT_ADC_F] && regs[IDX_PRI_B][BIT_ADC_E];
    pend[5] = regs[IDX_PRI_B][BIT_G3_F] && regs[IDX_PRI_B][BIT_G3_E];
    pend[6] = regs[IDX_PRI_B][BIT_G4_F] && regs[IDX_PRI_B][BIT_G4_E];
  end

  // Request drops right after a take so the same source is not seen twice
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_request <= 1'b0;
      irq_vector  <= VEC_BASE;
      served_idx  <= 3'h0;
    end
    else
    begin
      irq_request <= regs[IDX_PRI_A][BIT_GIE] && !stack_full &&
                     (|pend) && !ack_take;
      served_idx  <= highest(pend);
      irq_vector  <= vector_of(highest(pend));
    end
  end

  // ==========================================================
  // Checks
  property p_vec_order;
    @(posedge aclk) disable iff (!aresetn)
    irq_request |-> irq_vector == vector_of(highest($past(pend)));
  endproperty
  a_vec_order: assert property (p_vec_order)
    else $error("vector does not match highest pending source");

  property p_gate;
    @(posedge aclk) disable iff (!aresetn)
    irq_request |-> $past(regs[IDX_PRI_A][BIT_GIE]) && !$past(stack_full)
                    && $past(|pend);
  endproperty
  a_gate: assert property (p_gate)
    else $error("request without enable, with full stack or nothing pending");

  property p_gie_clr;
    @(posedge aclk) disable iff (!aresetn)
    ack_take |=> !regs[IDX_PRI_A][BIT_GIE] && !irq_request;
  endproperty
  a_gie_clr: assert property (p_gie_clr)
    else $error("global enable not cleared on take");

  property p_pin0_clr;
    @(posedge aclk) disable iff (!aresetn)
    ack_take && served_idx == 3'h0 && !pin_zero_event
      |=> !regs[IDX_PRI_A][BIT_PIN0_F];
  endproperty
  a_pin0_clr: assert property (p_pin0_clr)
    else $error("pin zero flag not cleared when served");

  property p_member_kept;
    @(posedge aclk) disable iff (!aresetn)
    ack_take && served_idx == 3'h2 && regs[IDX_GRP_B][BIT_TP_F] &&
      !wr_fire && !(|rise[3:2])
      |=> regs[IDX_GRP_B][BIT_TP_F] && !regs[IDX_PRI_A][BIT_G1_F];
  endproperty
  a_member_kept: assert property (p_member_kept)
    else $error("group serve changed member flag or kept group flag");

  property p_flag_no_en;
    @(posedge aclk) disable iff (!aresetn)
    converter_done |=> regs[IDX_PRI_B][BIT_ADC_F];
  endproperty
  a_flag_no_en: assert property (p_flag_no_en)
    else $error("converter event did not set its flag");

  property p_group_set;
    @(posedge aclk) disable iff (!aresetn)
    tmr_one_pmatch && regs[IDX_GRP_B][BIT_TP_E] &&
      !regs[IDX_GRP_B][BIT_TP_F] && !wr_fire
      |=> ##1 regs[IDX_PRI_A][BIT_G1_F];
  endproperty
  a_group_set: assert property (p_group_set)
    else $error("enabled member did not raise group one");

  property p_scf_reset;
    @(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> regs[IDX_GRP_E] == RST_GRP_E &&
                       regs[IDX_PRI_A] == 8'h00;
  endproperty
  a_scf_reset: assert property (p_scf_reset)
    else $error("wrong register value after reset");

  property p_rsvd;
    @(posedge aclk) disable iff (!aresetn)
    rvalid |-> (rdata[7:0] & ~reg_mask(rd_idx)) == 8'h00 && rdata[31:8] == 0;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("unimplemented bit read as one");

  property p_rhold;
    @(posedge aclk) disable iff (!aresetn)
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("read data dropped before taken");

  c_pin0: cover property (@(posedge aclk) disable iff (!aresetn)
    ack_take && served_idx == 3'h0);
  c_group4: cover property (@(posedge aclk) disable iff (!aresetn)
    ack_take && served_idx == 3'h6);
  c_blocked: cover property (@(posedge aclk) disable iff (!aresetn)
    regs[IDX_PRI_A][BIT_GIE] && (|pend) && stack_full);
  c_race: cover property (@(posedge aclk) disable iff (!aresetn)
    irq_request && $countones(pend) > 1);
endmodule

`default_nettype wire

//--- shared/irq_ctrl_pkg.sv
// Constants for the prioritised interrupt controller
package irq_ctrl_pkg;
  // ==========================================================
  // Register map
  localparam int         NUM_REGS   = 7;
  localparam int         NUM_VEC    = 7;
  localparam int         ADDR_W     = 8;
  localparam logic [2:0] IDX_PRI_A  = 3'h0;
  localparam logic [2:0] IDX_PRI_B  = 3'h1;
  localparam logic [2:0] IDX_GRP_A  = 3'h2;
  localparam logic [2:0] IDX_GRP_B  = 3'h3;
  localparam logic [2:0] IDX_GRP_C  = 3'h4;
  localparam logic [2:0] IDX_GRP_D  = 3'h5;
  localparam logic [2:0] IDX_GRP_E  = 3'h6;
  localparam logic [7:0] MASK_PRI_A = 8'h7f;
  localparam logic [7:0] MASK_PRI_B = 8'hff;
  localparam logic [7:0] MASK_GRP_A = 8'h77;
  localparam logic [7:0] MASK_GRP_BC = 8'h33;
  localparam logic [7:0] MASK_GRP_D = 8'hff;
  localparam logic [7:0] MASK_GRP_E = 8'hdf;
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [7:0] RST_GRP_E  = 8'h10;
  // ==========================================================
  // Field positions
  localparam int BIT_GIE    = 0;
  localparam int BIT_PIN0_E = 1;
  localparam int BIT_G0_E   = 2;
  localparam int BIT_G1_E   = 3;
  localparam int BIT_PIN0_F = 4;
  localparam int BIT_G0_F   = 5;
  localparam int BIT_G1_F   = 6;
  localparam int BIT_G2_E   = 0;
  localparam int BIT_ADC_E  = 1;
  localparam int BIT_G3_E   = 2;
  localparam int BIT_G4_E   = 3;
  localparam int BIT_G2_F   = 4;
  localparam int BIT_ADC_F  = 5;
  localparam int BIT_G3_F   = 6;
  localparam int BIT_G4_F   = 7;
  localparam int BIT_EE_F   = 6;
  localparam int BIT_EE_E   = 2;
  localparam int BIT_TA_F   = 5;
  localparam int BIT_TP_F   = 4;
  localparam int BIT_TA_E   = 1;
  localparam int BIT_TP_E   = 0;
  localparam int BIT_PIN1_F = 7;
  localparam int BIT_SPI1_F = 6;
  localparam int BIT_SPI0_F = 5;
  localparam int BIT_TB0_F  = 4;
  localparam int EN_OFS_D   = 4;
  localparam int BIT_LVD_F  = 7;
  localparam int BIT_TB1_F  = 6;
  localparam int BIT_SCF_F  = 4;
  localparam int BIT_LVD_E  = 3;
  localparam int BIT_TB1_E  = 2;
  localparam int BIT_CHP_E  = 1;
  localparam int BIT_SCF_E  = 0;
  // ==========================================================
  // Vectors and bus answers
  localparam logic [7:0] VEC_BASE    = 8'h04;
  localparam logic [7:0] VEC_STEP    = 8'h04;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- test/core_seq_model.sv
// Behavioural model of the core sequencer that takes interrupts
`timescale 1ns/1ps
`default_nettype none
module core_seq_model
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Request side
  input  wire logic       irq_request,
  input  wire logic [7:0] irq_vector,
  input  wire logic [1:0] ack_delay,
  output var  logic       irq_ack,
  // What was taken
  output var  logic [7:0] taken_vec,
  output var  logic [7:0] taken_cnt
);
  logic [1:0] wait_cnt;

  // ==========================================================
  // Acknowledge after a chosen wait; record only a real take
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_ack   <= 1'b0;
      wait_cnt  <= 2'h0;
      taken_vec <= 8'h00;
      taken_cnt <= 8'h00;
    end
    else if (irq_ack)
    begin
      // Vector is the one shown in the take cycle
      irq_ack  <= 1'b0;
      wait_cnt <= 2'h0;
      if (irq_request)
      begin
        taken_vec <= irq_vector;
        taken_cnt <= taken_cnt + 8'h01;
      end
    end
    else if (irq_request && wait_cnt == ack_delay)
      irq_ack <= 1'b1;
    else if (irq_request)
      wait_cnt <= wait_cnt + 2'h1;
    else
      wait_cnt <= 2'h0;
  end
endmodule
`default_nettype wire

//--- test/prioritised_irq_controller_test.sv
// Self-checking bench for the prioritised interrupt controller
`timescale 1ns/1ps
`default_nettype none
module prioritised_irq_controller_test;
  import irq_ctrl_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        stack_full, irq_ack, irq_request;
  logic [7:0]  awaddr, araddr, irq_vector, taken_vec, taken_cnt, fl;
  logic [31:0] wdata, rdata, rd_val;
  logic [1:0]  bresp, rresp, resp, ack_delay;
  logic [16:0] ev;
  int          fails, total_checks, cycles;

  prioritised_irq_controller uut
  (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'h1),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .pin_zero_event(ev[0]), .pin_one_event(ev[1]),
    .tmr_zero_amatch(ev[2]), .tmr_zero_pmatch(ev[3]),
    .tmr_one_amatch(ev[4]), .tmr_one_pmatch(ev[5]),
    .tmr_two_amatch(ev[6]), .tmr_two_pmatch(ev[7]),
    .eeprom_write_done(ev[8]), .converter_done(ev[9]),
    .timebase_zero_tick(ev[10]), .timebase_one_tick(ev[11]),
    .serial_zero_done(ev[12]), .serial_one_done(ev[13]),
    .voltage_detect_event(ev[14]), .scf_event(ev[15]),
    .charge_pump_event(ev[16]), .stack_full(stack_full),
    .irq_ack(irq_ack), .irq_request(irq_request), .irq_vector(irq_vector)
  );

  core_seq_model model
  (
    .aclk(aclk), .aresetn(aresetn), .irq_request(irq_request),
    .irq_vector(irq_vector), .ack_delay(ack_delay), .irq_ack(irq_ack),
    .taken_vec(taken_vec), .taken_cnt(taken_cnt)
  );

  // ==========================================================
  // Clock and hang guard
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      fails = fails + 1;
      conclude();
    end
  end

  // ==========================================================
  // Shared tasks
  task conclude();
    $display("Checks %0d, errors %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks = total_checks + 1;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      fails = fails + 1;
    end
  endtask

  // Address and data released each on its own handshake
  task wr(input logic [7:0] a, input logic [7:0] d);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task rd(input logic [7:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    rd_val = rdata;
    resp   = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge aclk);
    ev[i] <= 1'b0;
    @(posedge aclk);
  endtask

  task wait_take(input logic [7:0] n);
    for (int i = 0; i < 60 && taken_cnt !== n; i++) @(posedge aclk);
    chk("taken count", {24'h0, n}, {24'h0, taken_cnt});
  endtask

  function automatic logic [7:0] reg_mask(input int i);
    case (i)
      0:       return MASK_PRI_A;
      1:       return MASK_PRI_B;
      2:       return MASK_GRP_A;
      3, 4:    return MASK_GRP_BC;
      5:       return MASK_GRP_D;
      default: return MASK_GRP_E;
    endcase
  endfunction

  // ==========================================================
  // Main sequence
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, stack_full} = 6'h00;
    {awaddr, araddr, wdata, ev, ack_delay} = '0;
    aresetn = 1'b0;
    fails = 0;
    total_checks = 0;
    cycles = 0;
    void'($urandom(32'h5e25));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 7; i++)
    begin
      rd(8'(4 * i));
      chk("reset value", (i == 6) ? RST_GRP_E : RST_ZERO, rd_val);
    end
    // Random contents, global enable kept off so nothing is taken
    for (int i = 0; i < 21; i++)
    begin
      fl = 8'($urandom) & ((i % 7 == 0) ? 8'hfe : 8'hff);
      if (i % 7 == 6) fl = fl & 8'hdf;
      wr(8'(4 * (i % 7)), fl);
      chk("write ok", RESP_OKAY, resp);
      rd(8'(4 * (i % 7)));
      chk("readback", {24'h0, fl & reg_mask(i % 7)}, rd_val);
    end
    for (int i = 0; i < 7; i++) wr(8'(4 * i), 8'h00);
    for (int j = 0; j < 3; j++)
    begin
      fl = (j == 0) ? 8'h1c : (j == 1) ? 8'h02 : 8'h40;
      wr(fl, 8'hff);
      chk("write resp", RESP_SLVERR, resp);
      rd(fl);
      chk("read resp", RESP_SLVERR, resp);
      chk("read data", 0, rd_val);
    end
    // All seven pending at once, served one by one
    wr(8'h04, 8'hff);
    for (int k = 0; k < 7; k++)
    begin
      ack_delay <= 2'($urandom);
      fl = 8'h10 << k;
      fl = 8'h70 & ~(fl - 8'h01);
      wr(8'h00, fl | 8'h0f);
      wait_take(8'(k + 1));
      chk("vector", VEC_BASE + VEC_STEP * 8'(k), taken_vec);
      rd(8'h00);
      chk("global enable", 0, rd_val & 1);
    end
    rd(8'h04);
    chk("flags served", 32'h0f, rd_val);
    // Member event raises group one; member stays after service
    wr(8'h0c, 8'h01);
    pulse(5);
    rd(8'h0c);
    chk("member flag", 32'h11, rd_val);
    rd(8'h00);
    chk("group flag", 32'h4e, rd_val);
    wr(8'h00, 8'h49);
    wait_take(8'd8);
    chk("vector", 32'h0c, taken_vec);
    rd(8'h0c);
    chk("member kept", 32'h11, rd_val);
    rd(8'h00);
    chk("after take", 32'h08, rd_val);
    wr(8'h0c, 8'h01);
    // Disabled source, then full stack holding off the request
    wr(8'h04, 8'h00);
    pulse(9);
    rd(8'h04);
    chk("converter flag", 32'h20, rd_val);
    wr(8'h00, 8'h01);
    repeat (4) @(posedge aclk);
    chk("request", 0, {31'h0, irq_request});
    stack_full <= 1'b1;
    wr(8'h04, 8'h22);
    repeat (4) @(posedge aclk);
    chk("request", 0, {31'h0, irq_request});
    stack_full <= 1'b0;
    wait_take(8'd9);
    chk("vector", 32'h14, taken_vec);
    rd(8'h04);
    chk("converter served", 32'h02, rd_val);
    // Pump has no flag; its pulse with enable raises group four
    wr(8'h18, 8'h02);
    pulse(16);
    rd(8'h04);
    chk("pump group", 32'h82, rd_val);
    conclude();
  end
endmodule
`default_nettype wire
